// ### src/cwd_top.sv
// top: configuration word store, decode, reset delays and axi4-lite slave
//
// Notes on behaviour
// [R1] config word lives at location 2007h
// [R2] programmed bit reads zero, erased reads one
// [R3] config space reachable only in programming mode
// [R4] two select bits choose oscillator mode
// [R5] bit 6 one enables brown-out reset
// [R6] only config bit disables the watchdog
// [R7] watchdog runs from its own timebase
// [R8] start-up timer holds reset until oscillator stable
// [R9] power-up delay only after power-up
// [R10] sleep exits on reset, watchdog, interrupt
// [R11] power-up delay enable bit is active low
// [R12] programmer enables power-up delay with brown-out
`timescale 1ns/1ps
module cwd_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_on_event,
    input wire logic ext_reset,
    input wire logic brownout_detect,
    input wire logic osc_tick,
    input wire logic wake_interrupt,
    input wire logic sleep_request,
    input wire logic watchdog_clear,
    output logic [1:0] osc_mode,
    output logic brownout_reset_enable,
    output logic watchdog_enable,
    output logic powerup_delay_enable,
    output logic [1:0] code_protect,
    output logic core_reset,
    output logic sleeping,
    output logic watchdog_timeout
);
    typedef enum logic [1:0] {
        ST_RESET,
        ST_RUN,
        ST_SLEEP
    } cwd_state_t;

    typedef struct packed {
        logic [13:0] cfg;
        logic prog_mode;
        logic [15:0] prog_addr;
        logic aw_got;
        logic w_got;
        logic [15:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        cwd_state_t st;
        logic por_pend;
    } cwd_top_t;

    cwd_top_t s_q, s_d;
    logic powerup_delay_timer_busy, ost_busy, wdt_to, powerup_delay_timer_start, ost_start, crystal;
    logic aw_hs, w_hs, ar_hs, wr_go;
    logic [15:0] wr_addr;
    logic [31:0] wr_data, rd_val;
    logic cfg_sel_w, cfg_sel_r, rd_ok;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign osc_mode = {s_q.cfg[cwd_pkg::FOSC_HI_POS], s_q.cfg[cwd_pkg::FOSC_LO_POS]}; // [R4]
    assign brownout_reset_enable = s_q.cfg[cwd_pkg::BOR_EN_POS]; // [R5]
    assign watchdog_enable = s_q.cfg[cwd_pkg::WDT_EN_POS]; // [R6]
    assign powerup_delay_enable = ~s_q.cfg[cwd_pkg::POWERUP_DELAY_TIMER_EN_POS]; // [R11]
    assign code_protect = {s_q.cfg[cwd_pkg::CP_HI_POS], s_q.cfg[cwd_pkg::CP_LO_POS]};
    assign crystal = (osc_mode != cwd_pkg::OSC_RC);

    // ------------------------------------------------------------
    // axi handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_addr = s_q.aw_got ? s_q.awaddr : s_axi_awaddr;
    assign wr_data = s_q.w_got ? s_q.wdata : s_axi_wdata;
    assign wr_go = (s_q.aw_got || aw_hs) && (s_q.w_got || w_hs);
    assign cfg_sel_w = (wr_addr == cwd_pkg::REG_PROG_DATA) && (s_q.prog_addr == cwd_pkg::CFG_WORD_ADDR);
    assign cfg_sel_r = (s_axi_araddr == cwd_pkg::REG_CFG_WORD);

    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            cwd_pkg::REG_STATUS: rd_val = {21'h0, s_q.st == ST_SLEEP, ost_busy, powerup_delay_timer_busy,
                                           core_reset, code_protect, brownout_reset_enable,
                                           powerup_delay_enable, watchdog_enable, osc_mode};
            cwd_pkg::REG_CONTROL: rd_val = {31'h0, s_q.prog_mode};
            cwd_pkg::REG_PROG_ADDR: rd_val = {16'h0, s_q.prog_addr};
            default: begin
                if (cfg_sel_r && s_q.prog_mode) begin
                    rd_val = {18'h0, s_q.cfg}; // [R3]
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        powerup_delay_timer_start = 1'b0;
        ost_start = 1'b0;
        if (aw_hs) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = cwd_pkg::AXI_OKAY;
            if (wr_addr == cwd_pkg::REG_CONTROL) begin
                s_d.prog_mode = wr_data[0];
            end else if (wr_addr == cwd_pkg::REG_PROG_ADDR && s_q.prog_mode) begin
                s_d.prog_addr = wr_data[15:0];
            end else if (cfg_sel_w && s_q.prog_mode) begin
                // programming can only clear bits; erase is outside the block
                s_d.cfg = s_q.cfg & wr_data[13:0]; // [R2] [R1]
            end else if (wr_addr == cwd_pkg::REG_PROG_DATA && s_q.prog_mode
                         && s_q.prog_addr >= cwd_pkg::CFG_SPACE_LO && s_q.prog_addr <= cwd_pkg::CFG_SPACE_HI) begin
                s_d.bresp = cwd_pkg::AXI_OKAY; // [R3]
            end else begin
                s_d.bresp = cwd_pkg::AXI_SLVERR; // [R3]
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_ok ? cwd_pkg::AXI_OKAY : cwd_pkg::AXI_SLVERR;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // reset sequencing
        if (power_on_event) begin
            s_d.st = ST_RESET;
            s_d.por_pend = 1'b1;
            powerup_delay_timer_start = powerup_delay_enable; // [R9]
            ost_start = crystal; // [R8]
        end else if (ext_reset || wdt_to && s_q.st != ST_SLEEP
                     || brownout_detect && brownout_reset_enable) begin
            s_d.st = ST_RESET;
            ost_start = crystal; // [R8]
        end else begin
            case (s_q.st)
                ST_RESET: begin
                    if (!powerup_delay_timer_busy && !ost_busy) begin
                        s_d.st = ST_RUN;
                        s_d.por_pend = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (sleep_request) begin
                        s_d.st = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wdt_to || wake_interrupt) begin
                        s_d.st = ST_RUN; // [R10]
                    end
                end
                default: s_d.st = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.cfg <= cwd_pkg::CFG_ERASED; // [R2]
            s_q.st <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    cwd_startup_timer #(.COUNT(cwd_pkg::POWERUP_DELAY_TIMER_CYCLES)) u_powerup_delay_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(powerup_delay_timer_start),
        .tick(1'b1),
        .busy(powerup_delay_timer_busy)
    );
    cwd_startup_timer #(.COUNT(cwd_pkg::OST_OSC_CYCLES)) u_ost (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(ost_start),
        .tick(osc_tick),
        .busy(ost_busy)
    );
    cwd_watchdog u_wdt (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(watchdog_enable), // [R6]
        .clear(watchdog_clear),
        .timeout(wdt_to)
    );

    assign core_reset = (s_q.st == ST_RESET);
    assign sleeping = (s_q.st == ST_SLEEP);
    assign watchdog_timeout = wdt_to;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bor_decode: assert property (brownout_reset_enable == s_q.cfg[6]) // [R5]
        else $error("brown-out enable not bit 6");
    a_powerup_delay_timer_polarity: assert property (powerup_delay_enable == !s_q.cfg[3]) // [R11]
        else $error("power-up delay polarity wrong");
    a_osc_rc: assert property (s_q.cfg[1:0] == 2'h3 |-> osc_mode == cwd_pkg::OSC_RC) // [R4]
        else $error("rc mode decode wrong");
    a_cfg_hidden: assert property (ar_hs && cfg_sel_r && !s_q.prog_mode |=> s_axi_rresp == cwd_pkg::AXI_SLVERR) // [R3]
        else $error("config read outside programming");
    a_cfg_only_clears: assert property (1'b1 |=> (s_q.cfg & ~$past(s_q.cfg)) == 14'h0) // [R2]
        else $error("config bit went back to one");
    a_cfg_frozen: assert property (!s_q.prog_mode |=> s_q.cfg == $past(s_q.cfg)) // [R1]
        else $error("config changed outside programming");
    a_wdt_stays: assert property (watchdog_enable && !s_q.prog_mode |=> watchdog_enable) // [R6]
        else $error("watchdog turned off at run time");
    a_ost_hold: assert property (ost_busy |-> core_reset || s_q.st != ST_RUN) // [R8]
        else $error("left reset before oscillator stable");
    a_powerup_delay_timer_por_only: assert property (powerup_delay_timer_start |-> power_on_event) // [R9]
        else $error("power-up delay on other reset");
    a_sleep_wake: assert property (sleeping && wake_interrupt && !ext_reset && !power_on_event
                                   && !(brownout_detect && brownout_reset_enable) |=> !sleeping) // [R10]
        else $error("no wake on interrupt");
    c_write_cfg: cover property (wr_go && cfg_sel_w && s_q.prog_mode);
    c_wake: cover property (sleeping ##1 !sleeping);
    c_por_release: cover property (s_q.por_pend && core_reset ##1 !core_reset);
endmodule

// ### src/cwd_pkg.sv
// package: configuration word map, field positions and timing constants
package cwd_pkg;
    localparam logic [15:0] CFG_WORD_ADDR = 16'h2007;
    localparam logic [15:0] CFG_SPACE_LO = 16'h2000;
    localparam logic [15:0] CFG_SPACE_HI = 16'h3FFF;
    localparam logic [13:0] CFG_ERASED = 14'h3FFF;
    localparam int CFG_WIDTH = 14;
    localparam int FOSC_LO_POS = 0;
    localparam int FOSC_HI_POS = 1;
    localparam int WDT_EN_POS = 2;
    localparam int POWERUP_DELAY_TIMER_EN_POS = 3;
    localparam int CP_LO_POS = 4;
    localparam int CP_HI_POS = 5;
    localparam int BOR_EN_POS = 6;
    // axi byte addresses; config word sits at four times its word address 2007h
    localparam logic [15:0] REG_CFG_WORD = 16'h2007 << 2;
    localparam logic [15:0] REG_STATUS = 16'h0000;
    localparam logic [15:0] REG_CONTROL = 16'h0004;
    localparam logic [15:0] REG_PROG_DATA = 16'h0008;
    localparam logic [15:0] REG_PROG_ADDR = 16'h000C;
    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_RC = 2'h3;
    localparam int CLK_NS = 100;
    localparam int POWERUP_DELAY_TIMER_DELAY_NS = 72000;
    localparam int POWERUP_DELAY_TIMER_CYCLES = (POWERUP_DELAY_TIMER_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int OST_OSC_CYCLES = 1024;
    localparam int WDT_DIV = 8;
    localparam int WDT_TIMEOUT = 2048;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ### src/cwd_startup_timer.sv
// start-up timer: holds reset for a programmable number of ticks
`timescale 1ns/1ps
module cwd_startup_timer #(
    parameter int COUNT = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic tick,
    output logic busy
);
    typedef struct packed {
        logic busy;
        logic [31:0] cnt;
    } cwd_st_t;
    cwd_st_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 32'h0;
        end else if (s_q.busy && tick) begin
            if (s_q.cnt >= 32'(COUNT - 1)) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.cnt = s_q.cnt + 32'h1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign busy = s_q.busy;
endmodule

// ### src/cwd_watchdog.sv
// watchdog: own divided timebase, enable only from the configuration word
`timescale 1ns/1ps
module cwd_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic clear,
    output logic timeout
);
    typedef struct packed {
        logic [7:0] div;
        logic [15:0] cnt;
        logic to;
    } cwd_wd_t;
    cwd_wd_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.to = 1'b0;
        // private timebase, independent of the selected main oscillator
        s_d.div = (s_q.div >= 8'(cwd_pkg::WDT_DIV - 1)) ? 8'h00 : s_q.div + 8'h01; // [R7]
        if (!enable || clear) begin
            s_d.cnt = 16'h0000;
        end else if (s_q.div == 8'h00) begin
            if (s_q.cnt >= 16'(cwd_pkg::WDT_TIMEOUT - 1)) begin
                s_d.cnt = 16'h0000;
                s_d.to = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign timeout = s_q.to;
endmodule

// ### test/cwd_prog_model.sv
// programmer model: axi4-lite master that burns the configuration word
`timescale 1ns/1ps
module cwd_prog_model (
    input wire logic aclk,
    output logic [15:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [15:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = 67'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
    end
    // -----------------------------
    // bus cycles
    // -----------------------------
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'h0, ~a};
            if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'h0, ~d};
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'h0, ~a};
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // burns the word, leaves programming mode on
    task automatic burn(input logic [13:0] w, output logic [1:0] r);
        logic [13:0] v;
        v = w;
        if (v[cwd_pkg::BOR_EN_POS]) v[cwd_pkg::POWERUP_DELAY_TIMER_EN_POS] = 1'h0;
        wr(cwd_pkg::REG_CONTROL, 32'h1, r);
        wr(cwd_pkg::REG_PROG_ADDR, {16'h0, cwd_pkg::CFG_WORD_ADDR}, r);
        wr(cwd_pkg::REG_PROG_DATA, {18'h0, v}, r);
    endtask
endmodule

// ### test/cwd_top_tb.sv
// testbench for the configuration word decoder
`timescale 1ns/1ps
module cwd_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, power_on_event, ext_reset, brownout_detect;
    logic osc_tick, tick_en, wake_interrupt, sleep_request, watchdog_clear, brownout_reset_enable;
    logic watchdog_enable, powerup_delay_enable, core_reset, sleeping, watchdog_timeout;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, osc_mode, code_protect;
    int failures = 0;
    int checks = 0;
    int n;
    cwd_top uut (.*);
    cwd_prog_model prog (.*);
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) osc_tick <= tick_en & ~osc_tick;
    // -----------------------------
    // helpers
    // -----------------------------
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'h1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask
    task automatic power_up(input logic [13:0] w);
        do_reset();
        prog.burn(w, r);
        prog.wr(cwd_pkg::REG_CONTROL, 32'h0, r);
        power_on_event <= 1'h1;
        @(posedge aclk);
        power_on_event <= 1'h0;
    endtask
    // -----------------------------
    // scenarios
    // -----------------------------
    task automatic t_reset();
        do_reset();
        chk(osc_mode === 2'h3 && brownout_reset_enable === 1'h1, "erased decode");
        chk(watchdog_enable === 1'h1 && powerup_delay_enable === 1'h0, "erased enables");
        prog.rd(cwd_pkg::REG_STATUS, d, r);
        chk(r === 2'h0 && d[6:0] === 7'h77, "status");
        prog.rd(cwd_pkg::REG_CFG_WORD, d, r);
        chk(r === 2'h2, "word read outside programming");
        prog.rd(16'h0010, d, r);
        chk(r === 2'h2, "unmapped read");
        prog.wr(cwd_pkg::REG_CONTROL, 32'h1, r);
        prog.wr(cwd_pkg::REG_PROG_ADDR, 32'h3FFF, r);
        prog.wr(cwd_pkg::REG_PROG_DATA, 32'h0, r);
        chk(r === 2'h0, "top of config space");
        prog.wr(cwd_pkg::REG_PROG_ADDR, 32'h1FFF, r);
        prog.wr(cwd_pkg::REG_PROG_DATA, 32'h0, r);
        chk(r === 2'h2, "below config space");
        prog.rd(cwd_pkg::REG_CFG_WORD, d, r);
        chk(d[13:0] === 14'h3FFF, "word untouched");
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [13:0] w, e;
        for (int i = 0; i < 4; i++) begin
            w = {7'h7F, i[0], i[1:0], i[1], i[1], i[1:0]};
            e = w & ~{10'h0, w[6], 3'h0};
            do_reset();
            prog.burn(w, r);
            chk(r === 2'h0, "burn");
            prog.rd(cwd_pkg::REG_CFG_WORD, d, r);
            chk(r === 2'h0 && d[13:0] === e, "word readback");
            prog.wr(cwd_pkg::REG_CONTROL, 32'h0, r);
            chk(osc_mode === i[1:0] && code_protect === i[1:0], "oscillator select");
            chk(brownout_reset_enable === e[6] && watchdog_enable === e[2], "enables");
            chk(powerup_delay_enable === ~e[3], "power-up delay enable");
        end
        $display("test modes done");
    endtask
    task automatic t_powerup_delay_timer();
        power_up(14'h3FF7);
        repeat (700) @(posedge aclk);
        chk(core_reset === 1'h1, "held by power-up delay");
        for (n = 0; n < 100 && core_reset !== 1'h0; n++) @(posedge aclk);
        chk(core_reset === 1'h0, "power-up delay ends");
        ext_reset <= 1'h1;
        repeat (2) @(posedge aclk);
        ext_reset <= 1'h0;
        for (n = 0; n < 20 && core_reset !== 1'h0; n++) @(posedge aclk);
        chk(core_reset === 1'h0, "no delay after external reset");
        brownout_detect <= 1'h1;
        @(posedge aclk);
        brownout_detect <= 1'h0;
        @(posedge aclk);
        chk(core_reset === 1'h1, "brown-out resets when enabled");
        for (n = 0; n < 20 && core_reset !== 1'h0; n++) @(posedge aclk);
        chk(core_reset === 1'h0, "brown-out reset ends");
        watchdog_clear <= 1'h1;
        @(posedge aclk);
        {watchdog_clear, sleep_request} <= 2'h1;
        @(posedge aclk);
        sleep_request <= 1'h0;
        repeat (2) @(posedge aclk);
        chk(sleeping === 1'h1, "asleep");
        for (n = 0; n < 16500 && watchdog_timeout !== 1'h1; n++) @(posedge aclk);
        chk(n > 16300 && watchdog_timeout === 1'h1, "watchdog period");
        repeat (2) @(posedge aclk);
        chk(sleeping === 1'h0, "watchdog wakes");
        sleep_request <= 1'h1;
        @(posedge aclk);
        {sleep_request, wake_interrupt} <= 2'h1;
        repeat (3) @(posedge aclk);
        chk(sleeping === 1'h0, "interrupt wakes");
        wake_interrupt <= 1'h0;
        $display("test delays done");
    endtask
    task automatic t_ost();
        power_up(14'h3FBD);
        repeat (1500) @(posedge aclk);
        chk(core_reset === 1'h1, "no oscillator, held");
        tick_en <= 1'h1;
        repeat (1900) @(posedge aclk);
        chk(core_reset === 1'h1, "still counting");
        for (n = 0; n < 300 && core_reset !== 1'h0; n++) @(posedge aclk);
        chk(core_reset === 1'h0, "oscillator stable");
        tick_en <= 1'h0;
        $display("test start-up done");
    endtask
    initial begin
        #4000000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {aresetn, power_on_event, ext_reset, brownout_detect, tick_en, wake_interrupt} = 6'h0;
        {sleep_request, watchdog_clear, osc_tick} = 3'h0;
        s_axi_wstrb = 4'hF;
        t_reset();
        t_modes();
        t_powerup_delay_timer();
        t_ost();
        tally_and_finish();
    end
endmodule
